// [tas_alert_ctrl.sv]
// Purpose: Alarm status, masking and open-drain alert/overtemp outputs
// Assumes: Measurement sequencer and SMBus slave share core_clk and give one-cycle pulses
// Notes: Command byte accesses; read data returns one cycle after reg_rd
`timescale 1ns/1ps
`default_nettype none
module tas_alert_ctrl #(
  parameter int W = 8,
  parameter int SRC_DELAY_CYC = tas_pkg::SRC_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic ara_done,
  input wire logic conv_done,
  input wire logic [2:0] conv_chan,
  input wire logic [W-1:0] conv_value,
  input wire logic [W-1:0] conv_alert_lim,
  input wire logic [W-1:0] conv_ot_lim,
  input wire logic conv_fault,
  output logic alert_out_o,
  output logic alert_out_oe,
  output logic overtemp_output_o,
  output logic overtemp_output_oe,
  output logic src_pending
);
  localparam int CNT_W = $clog2(SRC_DELAY_CYC + 1);

  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  logic [7:0] cfg3_r;
  logic [7:0] st1_r;
  logic [7:0] st1_nxt;
  logic [7:0] st3_r;
  logic [7:0] st3_nxt;
  logic [7:0] ot_flag;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic alert_r;
  logic alert_nxt;
  logic ot_pin_r;
  logic pin_low_r;
  logic [W-1:0] pend_value_r;
  logic [W-1:0] pend_alim_r;
  logic [W-1:0] pend_olim_r;
  logic pend_fault_r;
  logic [CNT_W-1:0] cnt_r;
  tas_pkg::tas_dly_t dly_r;
  logic [6:0] upd;
  logic [6:0] al_over;
  logic [6:0] flt_val;

  wire logic src_en = cfg1_r[tas_pkg::CFG1_SRC_BIT];
  wire logic wr_cfg1 = reg_wr && reg_addr == tas_pkg::CMD_CFG1;
  wire logic wr_cfg2 = reg_wr && reg_addr == tas_pkg::CMD_CFG2;
  wire logic wr_cfg3 = reg_wr && reg_addr == tas_pkg::CMD_CFG3;
  wire logic rd_st1 = reg_rd && reg_addr == tas_pkg::CMD_ST1;
  wire logic rd_st2 = reg_rd && reg_addr == tas_pkg::CMD_ST2;
  wire logic alert_clr = rd_st1 || ara_done;
  wire logic src_start = conv_done && conv_chan == 3'(tas_pkg::SRC_CHAN) && src_en;
  wire logic dly_fire = dly_r == tas_pkg::TAS_DLY_WAIT && cnt_r == '0;

  // Per-channel comparison; channel 1 takes its delayed copy when cancellation ran
  genvar b;
  generate
    for (b = 0; b < tas_pkg::NCHAN; b++) begin : g_chan
      localparam int CH = (b == tas_pkg::LOCAL_BIT) ? 0 : b + 1;
      wire logic u_dir = conv_done && conv_chan == 3'(CH)
        && !(CH == tas_pkg::SRC_CHAN && src_en);
      wire logic u_dly = (CH == tas_pkg::SRC_CHAN) && dly_fire;
      wire logic [W-1:0] v = u_dir ? conv_value : pend_value_r;
      wire logic [W-1:0] al = u_dir ? conv_alert_lim : pend_alim_r;
      wire logic [W-1:0] ol = u_dir ? conv_ot_lim : pend_olim_r;
      assign upd[b] = u_dir || u_dly;
      assign al_over[b] = v > al;
      assign flt_val[b] = u_dir ? conv_fault : pend_fault_r;
      if (tas_pkg::ST2_MASK[b]) begin : g_ot
        tas_ot_hyst #(.W(W)) u_ot (
          .clk(core_clk),
          .rst_n(rst_n),
          .upd(upd[b]),
          .value(v),
          .limit(ol),
          .flag(ot_flag[b])
        );
      end else begin : g_no_ot
        assign ot_flag[b] = 1'b0;
      end
      // Flags update whatever the masks say; set beats the read clear
      assign st1_nxt[b] = (st1_r[b] && !rd_st1) || (upd[b] && al_over[b]);

      a_st1_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        upd[b] && al_over[b] |=> st1_r[b]) else $error("alert flag not set");
    end
  endgenerate
  assign ot_flag[7] = 1'b0;
  assign st1_nxt[7] = 1'b0;

  generate
    for (b = 0; b < 8; b++) begin : g_flt
      if (tas_pkg::ST3_MASK[b]) begin : g_on
        // Fault bit tracks the latest conversion of its diode channel
        assign st3_nxt[b] = upd[b-1] ? flt_val[b-1] : st3_r[b];
        a_fault_upd: assert property (@(posedge core_clk) disable iff (!rst_n)
          upd[b-1] |=> st3_r[b] == $past(flt_val[b-1]))
          else $error("diode fault bit wrong");
      end else begin : g_off
        assign st3_nxt[b] = 1'b0;
      end
    end
  endgenerate

  wire logic [6:0] al_unmask = st1_nxt[6:0] & ~cfg2_r[6:0];
  wire logic set_evt = |(upd & al_over & ~cfg2_r[6:0]);
  // Output only drops on clear or when nothing unmasked remains
  assign alert_nxt = ((alert_r && !alert_clr) || set_evt) && |al_unmask;
  wire logic ot_any = |(ot_flag & ~cfg3_r);

  wire logic [7:0] rd_mux =
    (reg_addr == tas_pkg::CMD_CFG1) ? cfg1_r :
    (reg_addr == tas_pkg::CMD_CFG2) ? cfg2_r :
    (reg_addr == tas_pkg::CMD_CFG3) ? cfg3_r :
    (reg_addr == tas_pkg::CMD_ST1) ? st1_r :
    (reg_addr == tas_pkg::CMD_ST2) ? ot_flag :
    (reg_addr == tas_pkg::CMD_ST3) ? st3_r : tas_pkg::REG_RST;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_r <= tas_pkg::REG_RST;
      cfg2_r <= tas_pkg::REG_RST;
      cfg3_r <= tas_pkg::REG_RST;
    end else begin
      if (wr_cfg1) begin
        cfg1_r <= reg_wdata & tas_pkg::CFG1_WMASK;
      end
      if (wr_cfg2) begin
        cfg2_r <= reg_wdata & tas_pkg::CFG2_WMASK;
      end
      if (wr_cfg3) begin
        cfg3_r <= reg_wdata & tas_pkg::CFG3_WMASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st1_r <= tas_pkg::REG_RST;
      st3_r <= tas_pkg::REG_RST;
      alert_r <= 1'b0;
      ot_pin_r <= 1'b0;
      pin_low_r <= 1'b0;
    end else begin
      st1_r <= st1_nxt;
      st3_r <= st3_nxt;
      alert_r <= alert_nxt;
      ot_pin_r <= ot_any;
      pin_low_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= tas_pkg::REG_RST;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Cancellation holds channel 1's result; a newer conversion restarts the wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_r <= tas_pkg::TAS_DLY_IDLE;
      cnt_r <= '0;
      pend_value_r <= '0;
      pend_alim_r <= '0;
      pend_olim_r <= '0;
      pend_fault_r <= 1'b0;
    end else if (src_start) begin
      dly_r <= tas_pkg::TAS_DLY_WAIT;
      cnt_r <= CNT_W'(SRC_DELAY_CYC - 1);
      pend_value_r <= conv_value;
      pend_alim_r <= conv_alert_lim;
      pend_olim_r <= conv_ot_lim;
      pend_fault_r <= conv_fault;
    end else begin
      case (dly_r)
        tas_pkg::TAS_DLY_WAIT: begin
          if (cnt_r == '0) begin
            dly_r <= tas_pkg::TAS_DLY_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          dly_r <= tas_pkg::TAS_DLY_IDLE;
        end
      endcase
    end
  end

  // Open-drain pins: the output level is always low, the enable pulls the wire
  assign alert_out_o = pin_low_r;
  assign alert_out_oe = alert_r;
  assign overtemp_output_o = pin_low_r;
  assign overtemp_output_oe = ot_pin_r;
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign src_pending = dly_r == tas_pkg::TAS_DLY_WAIT;

  sequence s_src_start;
    src_start;
  endsequence
  sequence s_src_armed;
    dly_r == tas_pkg::TAS_DLY_WAIT && cnt_r == CNT_W'(SRC_DELAY_CYC - 1);
  endsequence

  a_src_arm: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_src_start |=> s_src_armed) else $error("cancellation delay not armed");
  a_src_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    src_start |-> !upd[0]) else $error("channel 1 status updated early");
  a_st1_rdclr: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_st1 && !(|(upd & al_over)) |=> st1_r == 8'h00)
    else $error("status 1 not cleared by read");
  a_alert_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
    alert_clr && !set_evt |=> !alert_out_oe) else $error("alert not cleared");
  a_alert_reassert: assert property (@(posedge core_clk) disable iff (!rst_n)
    set_evt |=> alert_out_oe) else $error("alert not reasserted");
  a_alert_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    alert_out_oe |-> $past(|(st1_nxt[6:0] & ~cfg2_r[6:0])))
    else $error("alert driven by masked flag");
  a_ot_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
    ot_any |=> overtemp_output_oe) else $error("overtemp pin not driven");
  a_ot_rd: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_st2 && !(|upd) ##1 1'b1 |=> $stable(overtemp_output_oe) || $changed(cfg3_r))
    else $error("status 2 read changed overtemp pin");
  a_mask_reset: assert property (@(posedge core_clk)
    $rose(rst_n) |-> cfg2_r == 8'h00 && cfg3_r == 8'h00)
    else $error("mask registers not clear after reset");
  a_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_cfg3 |=> (cfg3_r & ~tas_pkg::CFG3_WMASK) == 8'h00 && !st1_r[7])
    else $error("reserved bits not zero");
  a_mask_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    upd[0] && al_over[0] && cfg2_r[0] |=> st1_r[0] && !$rose(alert_out_oe))
    else $error("mask stopped flag or leaked to pin");
endmodule // tas_alert_ctrl
`default_nettype wire

// [tas_host_model.sv]
// Purpose: Host side of the register strobe port, issuing single byte accesses
// Assumes: Requests start just after a rising edge and last one cycle
// Notes: Released lines show the inverse of their last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module tas_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Reading status 1 is how the host clears the alert pin
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // tas_host_model
`default_nettype wire

// [tas_ot_hyst.sv]
// Purpose: One overtemperature flag with trip above threshold and hysteretic release
// Assumes: upd pulses once per finished conversion of this channel
// Notes: Between trip and release the flag holds its last value
`timescale 1ns/1ps
`default_nettype none
module tas_ot_hyst #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic upd,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] limit,
  output logic flag
);
  logic flag_r;
  logic flag_nxt;
  wire logic [W:0] val_hy = {1'b0, value} + (W+1)'(tas_pkg::OT_HYST);
  wire logic trip = value > limit;
  // Covers both a falling value and a raised threshold
  wire logic release_ok = val_hy <= {1'b0, limit};
  assign flag_nxt = upd ? (trip | (flag_r & ~release_ok)) : flag_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag = flag_r;

  a_ot_trip: assert property (@(posedge clk) disable iff (!rst_n)
    upd && trip |=> flag_r) else $error("overtemp flag missed a trip");
  a_ot_release: assert property (@(posedge clk) disable iff (!rst_n)
    upd && release_ok |=> !flag_r) else $error("overtemp flag missed release");
  a_ot_band: assert property (@(posedge clk) disable iff (!rst_n)
    upd && !trip && !release_ok |=> flag_r == $past(flag_r))
    else $error("overtemp flag moved inside hysteresis band");
endmodule // tas_ot_hyst
`default_nettype wire

// [tas_pkg.sv]
// Purpose: Shared constants for the thermal alert status and mask block
// Assumes: Command bytes select registers; channel 0 is local, 1-3 diodes, 4-6 thermistors
// Notes: Status 1/2 bit b belongs to channel (b==6 ? 0 : b+1); status 3 bit b belongs to channel b
`default_nettype none
package tas_pkg;
  localparam logic [7:0] CMD_CFG1 = 8'h41;
  localparam logic [7:0] CMD_CFG2 = 8'h42;
  localparam logic [7:0] CMD_CFG3 = 8'h43;
  localparam logic [7:0] CMD_ST1 = 8'h44;
  localparam logic [7:0] CMD_ST2 = 8'h45;
  localparam logic [7:0] CMD_ST3 = 8'h46;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int CFG1_SRC_BIT = 3;
  localparam logic [7:0] CFG1_WMASK = 8'h08;
  localparam logic [7:0] CFG2_WMASK = 8'h7f;
  localparam logic [7:0] CFG3_WMASK = 8'h39;
  localparam logic [7:0] ST1_MASK = 8'h7f;
  localparam logic [7:0] ST2_MASK = 8'h39;
  localparam logic [7:0] ST3_MASK = 8'h0e;
  localparam int NCHAN = 7;
  localparam int LOCAL_BIT = 6;
  localparam int SRC_CHAN = 1;
  localparam logic [7:0] OT_HYST = 8'h04;
  localparam int CLK_HZ = 40000000;
  localparam int SRC_EXTRA_MS = 125;
  localparam int SRC_DELAY_CYC = SRC_EXTRA_MS * (CLK_HZ / 1000);
  typedef enum logic {
    TAS_DLY_IDLE = 1'b0,
    TAS_DLY_WAIT = 1'b1
  } tas_dly_t;
endpackage
`default_nettype wire

// [thermal_alert_status_mask_test.sv]
// Purpose: Directed register and conversion sequences against the alert block
// Assumes: Cancellation hold shortened to DLY cycles
// Notes: Expected bits come from the channel to bit mapping below
`timescale 1ns/1ps
`default_nettype none
module thermal_alert_status_mask_test;
  localparam int DLY = 20;
  localparam logic [7:0] C1 = tas_pkg::CMD_CFG1;
  localparam logic [7:0] C2 = tas_pkg::CMD_CFG2;
  localparam logic [7:0] C3 = tas_pkg::CMD_CFG3;
  localparam logic [7:0] S1 = tas_pkg::CMD_ST1;
  localparam logic [7:0] S2 = tas_pkg::CMD_ST2;
  localparam logic [7:0] S3 = tas_pkg::CMD_ST3;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conv_value, conv_alert_lim, conv_ot_lim;
  logic reg_wr, reg_rd, reg_rvalid, ara_done, conv_done, conv_fault, src_pending;
  logic alert_out_o, alert_out_oe, overtemp_output_o, overtemp_output_oe;
  logic [2:0] conv_chan;
  int err_total = 0;
  int checks_done = 0;
  int otc[4] = '{1, 4, 5, 6};
  always #12.5 core_clk = ~core_clk;
  tas_alert_ctrl #(.W(8), .SRC_DELAY_CYC(DLY)) tas_alert_ctrl_i (.core_clk(core_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ara_done(ara_done),
    .conv_done(conv_done), .conv_chan(conv_chan), .conv_value(conv_value),
    .conv_alert_lim(conv_alert_lim), .conv_ot_lim(conv_ot_lim), .conv_fault(conv_fault),
    .alert_out_o(alert_out_o), .alert_out_oe(alert_out_oe),
    .overtemp_output_o(overtemp_output_o), .overtemp_output_oe(overtemp_output_oe),
    .src_pending(src_pending));
  tas_host_model tas_host_model_i (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  // Local is channel 0 on bit 6; channel n otherwise sits on bit n-1
  function automatic logic [7:0] sbit(input int ch);
    return 8'h01 << ((ch == 0) ? 6 : ch - 1);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic k;
    tas_host_model_i.rd(a, v, k);
    chk({7'h00, k}, 8'h01);
    chk(v, exp);
  endtask
  task automatic pins(input logic a, input logic o);
    chk({4'h0, alert_out_o, overtemp_output_o, alert_out_oe, overtemp_output_oe}, {6'h00, a, o});
  endtask
  // Leaves two edges after the pulse so both pins have settled
  task automatic conv(input int ch, input logic [7:0] v, input logic [7:0] al,
                      input logic [7:0] ol, input logic f);
    @(posedge core_clk);
    #2;
    conv_chan = ch[2:0];
    conv_value = v;
    conv_alert_lim = al;
    conv_ot_lim = ol;
    conv_fault = f;
    conv_done = 1'b1;
    @(posedge core_clk);
    #2;
    conv_done = 1'b0;
    conv_value = ~v;
    @(posedge core_clk);
    #2;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 25);
    err_total++;
    print_verdict();
  end
  initial begin
    {ara_done, conv_done, conv_fault, conv_chan} = 6'h00;
    {conv_value, conv_alert_lim, conv_ot_lim} = 24'h000000;
    repeat (2) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    repeat (3) @(posedge core_clk);
    #2;
    pins(1'b0, 1'b0);
    rd_chk(C2, 8'h00);
    rd_chk(C3, 8'h00);
    rd_chk(S1, 8'h00);
    rd_chk(S2, 8'h00);
    rd_chk(S3, 8'h00);
    tas_host_model_i.wr(C2, 8'hff);
    rd_chk(C2, 8'h7f);
    tas_host_model_i.wr(C3, 8'hff);
    rd_chk(C3, 8'h39);
    tas_host_model_i.wr(8'h50, 8'hff);
    rd_chk(8'h50, 8'h00);
    $display("test reset and reserved bits done");
    for (int m = 0; m < 2; m++) begin
      for (int ch = 0; ch < 7; ch++) begin
        tas_host_model_i.wr(C2, (m == 1) ? sbit(ch) : 8'h00);
        conv(ch, 8'h40, 8'h40, 8'hff, 1'b0);
        rd_chk(S1, 8'h00);
        conv(ch, 8'h41, 8'h40, 8'hff, 1'b0);
        pins(m == 0, 1'b0);
        rd_chk(S1, sbit(ch));
        pins(1'b0, 1'b0);
        rd_chk(S1, 8'h00);
      end
    end
    $display("test alert flags and masks done");
    tas_host_model_i.wr(C2, 8'h00);
    conv(5, 8'h90, 8'h10, 8'hff, 1'b0);
    pins(1'b1, 1'b0);
    @(posedge core_clk);
    #2;
    ara_done = 1'b1;
    @(posedge core_clk);
    #2;
    ara_done = 1'b0;
    pins(1'b0, 1'b0);
    conv(5, 8'h90, 8'h10, 8'hff, 1'b0);
    pins(1'b1, 1'b0);
    rd_chk(S1, 8'h10);
    $display("test alert response done");
    tas_host_model_i.wr(C3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      conv(otc[i], 8'h51, 8'hff, 8'h50, 1'b0);
      pins(1'b0, 1'b1);
      rd_chk(S2, sbit(otc[i]));
      pins(1'b0, 1'b1);
      conv(otc[i], 8'h4d, 8'hff, 8'h50, 1'b0);
      pins(1'b0, 1'b1);
      tas_host_model_i.wr(C3, sbit(otc[i]));
      rd_chk(S2, sbit(otc[i]));
      pins(1'b0, 1'b0);
      tas_host_model_i.wr(C3, 8'h00);
      conv(otc[i], 8'h4c, 8'hff, 8'h50, 1'b0);
      pins(1'b0, 1'b0);
      rd_chk(S2, 8'h00);
    end
    $display("test overtemp done");
    for (int ch = 1; ch < 4; ch++) begin
      conv(ch, 8'h10, 8'hff, 8'hff, 1'b1);
      rd_chk(S3, 8'h01 << ch);
      conv(ch, 8'h10, 8'hff, 8'hff, 1'b0);
      rd_chk(S3, 8'h00);
    end
    $display("test diode faults done");
    tas_host_model_i.wr(C1, 8'hff);
    rd_chk(C1, 8'h08);
    conv(1, 8'h41, 8'h40, 8'hff, 1'b0);
    chk({7'h00, src_pending}, 8'h01);
    rd_chk(S1, 8'h00);
    repeat (DLY) @(posedge core_clk);
    #2;
    chk({7'h00, src_pending}, 8'h00);
    rd_chk(S1, 8'h01);
    $display("test resistance cancellation done");
    print_verdict();
  end
endmodule // thermal_alert_status_mask_test
`default_nettype wire
